// ==== dmart_core.sv ====
// How it works
// - a transfer is source read cycles then destination write cycles
// - word transfer at odd addresses adds one read and one write cycle
// - special area or software-wait access costs one extra bus cycle
// - all cycle counts are counted in bus clock periods
// - word transfer on byte bus uses two reads and two writes
// - unit cycles are reads times j plus writes times k
// - byte transfers 1+1; word 1+1 even, 2+2 odd
// - coefficient 1 without wait, 2 with wait or special area
// - any mix of even and odd source and destination accepted
// - enable write loads forward pointer and counter at first transfer
// - rewriting enable while active repeats the reload
// - request flag sets on request regardless of enable
// - request flag clears just before the transfer starts
// - software may clear request flag; writing one does nothing
// - peripheral requests set the flag with the interrupt flag
// - pin request sets flag on the selected pin edge
// - simultaneous requests set both flags; first channel goes first
// - after each channel transfer the CPU gets one bus access
// - single mode underflow clears enable and deactivates channel
// - repeat mode underflow reloads counter, channel stays active
// - interrupt request pulses on counter underflow
// - fixed pointers writable only when disabled; forward always
//
// Implementation choices: the register addresses and strobed register access.
`default_nettype none
`include "dmart_regs.svh"
module dmart_core
  import dmart_pkg::*;
#(
  parameter int NCH = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  input  wire logic [14:0]      periph_irq_i,
  input  wire logic [NCH-1:0]   external_request_pin_i,
  output logic                  bus_grant_req_o,
  input  wire logic             bus_ack_i,
  output dmart_bus_t            bus_o,
  input  wire logic [15:0]      bus_rdata_i,
  output logic      [NCH-1:0]   dma_irq_o
);

  // per-channel registers
  logic [31:0]    ctrl   [NCH];
  logic [19:0]    src    [NCH];
  logic [19:0]    dst    [NCH];
  logic [15:0]    rld    [NCH];
  logic [15:0]    cnt    [NCH];
  logic [19:0]    fptr   [NCH];
  logic [NCH-1:0] reqf;
  logic [NCH-1:0] fresh;
  logic [NCH-1:0] pin_q;
  logic [NCH-1:0] trig;

  dmart_state_t state;
  logic         cur;
  logic [2:0]   left;
  logic [1:0]   sub;
  logic [15:0]  data;
  logic         rd_pend;

  function automatic logic [1:0] coef(input logic sfa, input logic wt);
    coef = (sfa || wt) ? `DMART_COEF_WAIT : `DMART_COEF_NOWAIT;
  endfunction

  function automatic logic [2:0] nacc(input logic word, input logic bbus,
                                      input logic odd);
    if (!word)
      nacc = 3'h1;
    else if (bbus || odd)
      nacc = 3'h2;
    else
      nacc = 3'h1;
  endfunction

  function automatic logic sel_ch(input logic [7:0] a);
    sel_ch = a[5];
  endfunction

  logic [31:0] c_cur;
  logic        cur_srcfwd;
  logic [19:0] rd_addr;
  logic [19:0] wr_addr;
  logic        last_unit;
  assign c_cur      = ctrl[cur];
  assign cur_srcfwd = c_cur[`DMART_C_SRCFWD];
  assign rd_addr    = cur_srcfwd ? fptr[cur] : src[cur];
  assign wr_addr    = cur_srcfwd ? dst[cur] : fptr[cur];
  assign last_unit  = (cnt[cur] == 16'h0000);

  // request sources
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_trig
      logic [3:0] s;
      logic       rise;
      logic       fall;
      assign s    = ctrl[g][`DMART_C_SRCSEL +: 4];
      assign rise = external_request_pin_i[g] && !pin_q[g];
      assign fall = !external_request_pin_i[g] && pin_q[g];
      always_comb begin
        if (s == `DMART_SRCSEL_SW)
          trig[g] = reg_wr_i && sel_ch(reg_addr_i) == g[0]
            && (reg_addr_i & `DMART_REG_MASK) == `DMART_CTRL0
            && reg_wdata_i[`DMART_C_SWREQ];
        else if (s == `DMART_SRCSEL_PIN)
          trig[g] = ctrl[g][`DMART_C_EDGE] ? (rise || fall) : fall;
        else
          trig[g] = periph_irq_i[s - 4'h1];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i)
      pin_q <= '0;
    else
      pin_q <= external_request_pin_i;
  end

  logic go;
  logic go_ch;
  // first channel wins when both pending; CPU slot follows every unit
  assign go_ch = (reqf[0] && ctrl[0][`DMART_C_EN]) ? 1'b0 : 1'b1;
  assign go    = (state == DMART_IDLE)
                 && |(reqf & {ctrl[1][`DMART_C_EN], ctrl[0][`DMART_C_EN]});

  // request flags
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reqf <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // set wins over a clear in the same cycle
        if (go && go_ch == i[0])
          reqf[i] <= 1'b0;
        if (reg_wr_i && sel_ch(reg_addr_i) == i[0]
            && (reg_addr_i & `DMART_REG_MASK) == `DMART_CTRL0
            && !reg_wdata_i[`DMART_C_REQ])
          reqf[i] <= 1'b0;
        if (trig[i])
          reqf[i] <= 1'b1;
      end
    end
  end

  // control and pointer registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl[i] <= `DMART_CTRL_RST;
        src[i]  <= '0;
        dst[i]  <= '0;
        rld[i]  <= '0;
      end
      fresh <= '0;
    end else begin
      // reload happens once per enable; a same-cycle enable write re-arms
      if (go && fresh[go_ch])
        fresh[go_ch] <= 1'b0;
      if (reg_wr_i) begin
        case (reg_addr_i & `DMART_REG_MASK)
          `DMART_CTRL0: begin
            ctrl[sel_ch(reg_addr_i)] <= reg_wdata_i;
            if (reg_wdata_i[`DMART_C_EN])
              fresh[sel_ch(reg_addr_i)] <= 1'b1;
          end
          `DMART_SRC0: begin
            if (ctrl[sel_ch(reg_addr_i)][`DMART_C_SRCFWD]
                || !ctrl[sel_ch(reg_addr_i)][`DMART_C_EN])
              src[sel_ch(reg_addr_i)] <= reg_wdata_i[19:0];
          end
          `DMART_DST0: begin
            if (!ctrl[sel_ch(reg_addr_i)][`DMART_C_SRCFWD]
                || !ctrl[sel_ch(reg_addr_i)][`DMART_C_EN])
              dst[sel_ch(reg_addr_i)] <= reg_wdata_i[19:0];
          end
          `DMART_RLD0: rld[sel_ch(reg_addr_i)] <= reg_wdata_i[15:0];
          default: ;
        endcase
      end
      if (state == DMART_WRITE && bus_ack_i && sub == 2'h1
          && left == 3'h1 && last_unit && !c_cur[`DMART_C_RPT])
        ctrl[cur][`DMART_C_EN] <= 1'b0;
    end
  end

  // transfer engine; each access holds coef cycles of bus clock
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state     <= DMART_IDLE;
      cur       <= 1'b0;
      left      <= '0;
      sub       <= '0;
      data      <= '0;
      rd_pend   <= 1'b0;
      dma_irq_o <= '0;
      for (int i = 0; i < NCH; i++) begin
        cnt[i]  <= '0;
        fptr[i] <= '0;
      end
    end else begin
      dma_irq_o <= '0;
      unique case (state)
        DMART_IDLE: begin
          if (go) begin
            cur     <= go_ch;
            state   <= DMART_READ;
            rd_pend <= 1'b1;
            if (fresh[go_ch]) begin
              fptr[go_ch] <= ctrl[go_ch][`DMART_C_SRCFWD]
                             ? src[go_ch] : dst[go_ch];
              cnt[go_ch]  <= rld[go_ch];
            end
          end
        end
        DMART_READ: begin
          if (rd_pend) begin
            rd_pend <= 1'b0;
            left <= nacc(c_cur[`DMART_C_WORD], c_cur[`DMART_C_BYTEBUS],
                         rd_addr[0]);
            sub  <= coef(c_cur[`DMART_C_SRCSFA], c_cur[`DMART_C_SRCWAIT]);
          end else if (bus_ack_i) begin
            // lower byte first, then upper
            if (sub != 2'h1) begin
              sub <= sub - 2'h1;
            end else begin
              if (left == 3'h2)
                data[7:0] <= bus_rdata_i[7:0];
              else if (left == 3'h1 && c_cur[`DMART_C_WORD]
                       && nacc(1'b1, c_cur[`DMART_C_BYTEBUS],
                               rd_addr[0]) == 3'h2)
                data[15:8] <= bus_rdata_i[7:0];
              else
                data <= bus_rdata_i;
              left <= left - 3'h1;
              sub  <= coef(c_cur[`DMART_C_SRCSFA], c_cur[`DMART_C_SRCWAIT]);
              if (left == 3'h1) begin
                state <= DMART_WRITE;
                left  <= nacc(c_cur[`DMART_C_WORD],
                              c_cur[`DMART_C_BYTEBUS], wr_addr[0]);
                sub   <= coef(c_cur[`DMART_C_DSTSFA],
                              c_cur[`DMART_C_DSTWAIT]);
              end
            end
          end
        end
        DMART_WRITE: begin
          if (bus_ack_i) begin
            if (sub != 2'h1) begin
              sub <= sub - 2'h1;
            end else begin
              left <= left - 3'h1;
              sub  <= coef(c_cur[`DMART_C_DSTSFA], c_cur[`DMART_C_DSTWAIT]);
              if (left == 3'h1) begin
                state <= DMART_CPU;
                fptr[cur] <= fptr[cur]
                  + (c_cur[`DMART_C_WORD] ? 20'h00002 : 20'h00001);
                if (last_unit) begin
                  dma_irq_o[cur] <= 1'b1;
                  cnt[cur] <= c_cur[`DMART_C_RPT] ? rld[cur] : 16'h0000;
                end else begin
                  cnt[cur] <= cnt[cur] - 16'h0001;
                end
              end
            end
          end
        end
        DMART_CPU: begin
          // one cycle with bus released lets the CPU take one access
          state <= DMART_IDLE;
        end
        default: state <= DMART_IDLE;
      endcase
    end
  end

  // bus drive
  logic half;
  // second byte of a split word, byte bus or odd address alike
  assign half = (left == 3'h1) && c_cur[`DMART_C_WORD]
                && (c_cur[`DMART_C_BYTEBUS] || wr_addr[0]);
  always_comb begin
    bus_grant_req_o = (state == DMART_READ) || (state == DMART_WRITE);
    bus_o.req   = bus_grant_req_o && !rd_pend;
    bus_o.write = (state == DMART_WRITE);
    bus_o.word  = c_cur[`DMART_C_WORD] && !c_cur[`DMART_C_BYTEBUS]
                  && !((state == DMART_WRITE) ? wr_addr[0] : rd_addr[0]);
    bus_o.addr  = ((state == DMART_WRITE) ? wr_addr : rd_addr)
                  + ((left == 3'h1 && c_cur[`DMART_C_WORD]
                      && (c_cur[`DMART_C_BYTEBUS]
                          || ((state == DMART_WRITE) ? wr_addr[0]
                                                     : rd_addr[0])))
                     ? 20'h00001 : 20'h00000);
    bus_o.wdata = half ? {8'h00, data[15:8]} : data;
  end

  // register reads
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i & `DMART_REG_MASK)
        `DMART_CTRL0: begin
          reg_rdata_o <= ctrl[sel_ch(reg_addr_i)];
          reg_rdata_o[`DMART_C_REQ] <= reqf[sel_ch(reg_addr_i)];
        end
        `DMART_SRC0: reg_rdata_o <= {12'h000,
          (ctrl[sel_ch(reg_addr_i)][`DMART_C_EN]
           && ctrl[sel_ch(reg_addr_i)][`DMART_C_SRCFWD])
          ? fptr[sel_ch(reg_addr_i)] : src[sel_ch(reg_addr_i)]};
        `DMART_DST0: reg_rdata_o <= {12'h000,
          (ctrl[sel_ch(reg_addr_i)][`DMART_C_EN]
           && !ctrl[sel_ch(reg_addr_i)][`DMART_C_SRCFWD])
          ? fptr[sel_ch(reg_addr_i)] : dst[sel_ch(reg_addr_i)]};
        `DMART_RLD0: reg_rdata_o <= {16'h0000, rld[sel_ch(reg_addr_i)]};
        `DMART_STAT0: reg_rdata_o <= {cnt[sel_ch(reg_addr_i)], 15'h0000,
          ctrl[sel_ch(reg_addr_i)][`DMART_C_EN]};
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule
`default_nettype wire

// ==== dmart_core_asserts.sv ====
`default_nettype none
module dmart_core_asserts
  import dmart_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic           clk_sys_i,
  input wire logic           sys_rst_i,
  input wire logic [7:0]     reg_addr_i,
  input wire logic [31:0]    reg_wdata_i,
  input wire logic           reg_wr_i,
  input wire logic           reg_rd_i,
  input wire logic [31:0]    reg_rdata_o,
  input wire logic [14:0]    periph_irq_i,
  input wire logic [NCH-1:0] external_request_pin_i,
  input wire logic           bus_grant_req_o,
  input wire logic           bus_ack_i,
  input wire dmart_bus_t     bus_o,
  input wire logic [15:0]    bus_rdata_i,
  input wire logic [NCH-1:0] dma_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  AST_REQ_IN_GRANT: assert property (
    bus_o.req |-> bus_grant_req_o) else $error("access off grant");
  AST_READ_FIRST: assert property (
    $rose(bus_grant_req_o) |-> ##[0:1] (bus_o.req && !bus_o.write))
    else $error("unit not opened by read");
  AST_WRITE_LAST: assert property (
    $fell(bus_grant_req_o) |-> $past(bus_o.req && bus_o.write))
    else $error("unit not closed by write");
  AST_CPU_SLOT: assert property (
    $fell(bus_grant_req_o) |=> !bus_grant_req_o)
    else $error("no cpu slot");
  AST_ACCESS_STANDS: assert property (
    bus_o.req && !bus_ack_i |=> $stable(bus_o)) else $error("access moved");
  AST_ODD_WORD: assert property (
    bus_o.req && bus_o.word |-> !bus_o.addr[0])
    else $error("odd word access");
  AST_IRQ_PULSE: assert property (
    |dma_irq_o |=> (dma_irq_o & $past(dma_irq_o)) == '0)
    else $error("irq too long");
  AST_UNIT_BOUND: assert property (
    $rose(bus_grant_req_o) |-> ##[1:40] !bus_grant_req_o)
    else $error("unit too long");
endmodule
bind dmart_core dmart_core_asserts #(.NCH(NCH)) dmart_core_asserts_inst (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .periph_irq_i(periph_irq_i),
  .external_request_pin_i(external_request_pin_i),
  .bus_grant_req_o(bus_grant_req_o), .bus_ack_i(bus_ack_i), .bus_o(bus_o),
  .bus_rdata_i(bus_rdata_i), .dma_irq_o(dma_irq_o));
`default_nettype wire

// ==== dmart_core_tb.sv ====
`default_nettype none
module dmart_core_tb
  import dmart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, wr_s, rd_s, grant, ack, slow;
  logic [7:0]  addr;
  logic [31:0] wdat, rdat, d;
  logic [14:0] pirq;
  logic [15:0] brd;
  logic [1:0]  pin, irq;
  dmart_bus_t  bus;
  logic [19:0] wq[$];
  int          n_fail, num_checks, cyc, nacc, n0, i0, irqs[2];
  // byte, byte odd, word, word odd, src wait, dst special, byte bus
  logic [31:0] cctl[7] = '{32'h23, 32'h23, 32'h27, 32'h27, 32'h2027,
                           32'h10027, 32'h20027};
  logic [7:0]  cadr[7] = '{8'h10, 8'h11, 8'h10, 8'h11, 8'h10, 8'h11, 8'h10};
  int          cexp[7] = '{2, 2, 2, 4, 3, 6, 4};
  int          ecnt[4] = '{1, 0, 2, 1};
  dmart_core dmart_core_inst (
    .clk_sys_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat),
    .periph_irq_i(pirq), .external_request_pin_i(pin),
    .bus_grant_req_o(grant), .bus_ack_i(ack), .bus_o(bus),
    .bus_rdata_i(brd), .dma_irq_o(irq));
  dmart_mem_model dmart_mem_model_inst (
    .clk_sys_i(clk), .sys_rst_i(rst), .bus_i(bus), .slow_i(slow),
    .ack_o(ack), .rdata_o(brd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    nacc += int'(bus.req && ack);
    if (bus.req && ack && bus.write) wq.push_back(bus.addr);
    for (int k = 0; k < 2; k++) irqs[k] += int'(irq[k]);
    // run needs about 400 cycles
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    addr <= a;
    wdat <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdat;
    @(posedge clk);
  endtask
  task automatic cfg(logic [7:0] a, logic [31:0] v);
    wr(a, v);
    wr(a, v & 32'hFFFFFFFD);
  endtask
  task automatic quiet;
    int q;
    q = 0;
    while (q < 12) begin
      @(posedge clk);
      q = grant ? 0 : q + 1;
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rst, wr_s, rd_s, slow, addr, wdat, pirq, pin} = {4'h8, 55'h0, 2'h3};
    for (int i = 0; i < 256; i++) dmart_mem_model_inst.mem[i] = 8'(i) ^ 8'h5A;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      wr(8'h04, {24'h0, cadr[i]});
      wr(8'h08, {24'h0, cadr[i] + 8'h30});
      wr(8'h0C, 32'h0);
      {n0, i0} = {nacc, irqs[0]};
      wr(8'h00, cctl[i]);
      quiet;
      chk("cycles", 32'(nacc - n0), 32'(cexp[i]));
      chk("irq", 32'(irqs[0] - i0), 32'h1);
      rd(8'h10);
      chk("en", {31'h0, d[0]}, 32'h0);
    end
    chk("copy", {24'h0, dmart_mem_model_inst.mem[8'h40]}, 32'h4A);
    n0 = nacc;
    wr(8'h00, 32'h22);
    quiet;
    rd(8'h00);
    chk("flag off", {31'h0, d[1]}, 32'h1);
    chk("no xfer", 32'(nacc - n0), 32'h0);
    wr(8'h00, 32'h0);
    rd(8'h00);
    chk("clear", {31'h0, d[1]}, 32'h0);
    wr(8'h00, 32'h2);
    rd(8'h00);
    chk("set one", {31'h0, d[1]}, 32'h0);
    slow <= 1'b1;
    wr(8'h08, 32'h60);
    wr(8'h0C, 32'h2);
    cfg(8'h00, 32'h10F);
    i0 = irqs[0];
    for (int u = 0; u < 4; u++) begin
      if (u == 3) cfg(8'h00, 32'h10F);
      pirq <= 15'h1;
      @(posedge clk);
      pirq <= 15'h0;
      quiet;
      rd(8'h10);
      chk("count", {16'h0, d[31:16]}, 32'(ecnt[u]));
      chk("dst", {12'h0, wq[$]}, 32'h60 + 32'(2 * (u % 3)));
      chk("active", {31'h0, d[0]}, 32'h1);
    end
    chk("rpt irq", 32'(irqs[0] - i0), 32'h1);
    slow <= 1'b0;
    wr(8'h08, 32'h80);
    wr(8'h0C, 32'h0);
    wr(8'h24, 32'h12);
    wr(8'h28, 32'hA0);
    wr(8'h2C, 32'h0);
    cfg(8'h20, 32'hF03);
    cfg(8'h00, 32'hF03);
    wq.delete();
    i0 = irqs[1];
    pin <= 2'h0;
    quiet;
    chk("first", {12'h0, wq[0]}, 32'h80);
    chk("second", {12'h0, wq[$]}, 32'hA0);
    chk("irq1", 32'(irqs[1] - i0), 32'h1);
    pin <= 2'h3;
    quiet;
    rd(8'h00);
    chk("rise", {31'h0, d[1]}, 32'h0);
    pin <= 2'h2;
    quiet;
    rd(8'h00);
    chk("fall", {31'h0, d[1]}, 32'h1);
    final_report;
  end
endmodule
`default_nettype wire

// ==== dmart_mem_model.sv ====
`default_nettype none
module dmart_mem_model
  import dmart_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire dmart_bus_t bus_i,
  input  wire logic       slow_i,
  output logic            ack_o,
  output logic [15:0]     rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] a;
  logic       tog;
  logic       w;
  assign a = bus_i.addr[7:0];
  // slow mode acks every other cycle, stretching each access
  assign ack_o = bus_i.req && !(slow_i && tog);
  assign w = ack_o && bus_i.write;
  // idle lanes toggle so stale data never looks valid
  assign rdata_o = (bus_i.req && !bus_i.write) ?
                   {bus_i.word ? mem[a + 8'h01] : mem[a], mem[a]} : {16{tog}};
  always @(posedge clk_sys_i) begin
    tog <= sys_rst_i ? 1'b0 : !tog;
    if (w) mem[a] <= bus_i.wdata[7:0];
    if (w && bus_i.word) mem[a + 8'h01] <= bus_i.wdata[15:8];
  end
endmodule
`default_nettype wire

// ==== dmart_pkg.sv ====
`default_nettype none
package dmart_pkg;
  typedef enum logic [2:0] {
    DMART_IDLE  = 3'b000,
    DMART_READ  = 3'b001,
    DMART_WRITE = 3'b010,
    DMART_CPU   = 3'b011
  } dmart_state_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } dmart_bus_t;
endpackage
`default_nettype wire

// ==== dmart_regs.svh ====
`ifndef DMART_REGS_SVH
`define DMART_REGS_SVH
// register byte addresses (word aligned, byte address = index * 4)
`define DMART_CTRL0      8'h00
`define DMART_SRC0       8'h04
`define DMART_DST0       8'h08
`define DMART_RLD0       8'h0C
`define DMART_STAT0      8'h10
`define DMART_CTRL1      8'h20
`define DMART_SRC1       8'h24
`define DMART_DST1       8'h28
`define DMART_RLD1       8'h2C
`define DMART_STAT1      8'h30
`define DMART_CH_STRIDE  8'h20
`define DMART_REG_MASK   8'h1F
// control field positions
`define DMART_C_EN       0
`define DMART_C_REQ      1
`define DMART_C_WORD     2
`define DMART_C_RPT      3
`define DMART_C_SRCFWD   4
`define DMART_C_SWREQ    5
`define DMART_C_SRCSEL   8
`define DMART_C_EDGE     12
`define DMART_C_SRCWAIT  13
`define DMART_C_DSTWAIT  14
`define DMART_C_SRCSFA   15
`define DMART_C_DSTSFA   16
`define DMART_C_BYTEBUS  17
// status fields
`define DMART_S_ACTIVE   0
`define DMART_S_CNT      16
// coefficients, request source selects and control reset value
`define DMART_COEF_NOWAIT 2'h1
`define DMART_COEF_WAIT   2'h2
`define DMART_SRCSEL_SW   4'h0
`define DMART_SRCSEL_PIN  4'hF
`define DMART_CTRL_RST    32'h0000_0000
`endif
